/* File: include/umf_pkg.sv */
package umf_pkg;

  // ==========================================================================
  // bus geometry
  localparam int          ADDR_W      = 8;      // byte address bits decoded
  localparam int          DATA_W      = 32;     // bus data width
  localparam logic [1:0]  HTRANS_IDLE = 2'h0;   // idle transfer
  localparam logic        HRESP_OKAY  = 1'b0;   // the only answer given

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_MLS  = 8'h00;  // modem_line_status
  localparam logic [ADDR_W-1:0] ADDR_SCR  = 8'h04;  // scratch_store
  localparam logic [ADDR_W-1:0] ADDR_EFC  = 8'h08;  // extended_feature_ctrl
  localparam logic [ADDR_W-1:0] ADDR_MCTL = 8'h0c;  // manual modem control
  localparam logic [ADDR_W-1:0] ADDR_IST  = 8'h10;  // interrupt status, read clears
  localparam logic [ADDR_W-1:0] ADDR_IMSK = 8'h14;  // interrupt mask
  localparam logic [ADDR_W-1:0] ADDR_FLOW = 8'h18;  // flow control state

  // ==========================================================================
  // field positions and widths
  localparam int CHG_W        = 4;   // change flags in modem_line_status
  localparam int EFC_AUTO_CTS = 7;   // automatic cts enable
  localparam int EFC_AUTO_RTS = 6;   // automatic rts enable
  localparam int EFC_ENH      = 4;   // enhanced function enable
  localparam int MCTL_SW_RTS  = 0;   // software rts request
  localparam int IST_MODEM    = 0;   // modem line change event
  localparam int IST_RXTRIG   = 1;   // receive trigger reached event
  localparam int IST_W        = 2;   // events held in interrupt status
  localparam int LVL_W        = 6;   // receive fifo fill count width

  // ==========================================================================
  // reset values
  localparam logic [7:0]       SCR_RST     = 8'hff;
  localparam logic [7:0]       EFC_RST     = 8'h00;
  localparam logic [7:0]       MCTL_RST    = 8'h00;
  localparam logic [IST_W-1:0] IMSK_RST    = 2'h0;
  localparam logic             RTS_PIN_RST = 1'b1;
  localparam logic [3:0]       PIN_IDLE    = 4'hf;  // modem pins idle high

  // ==========================================================================
  // types
  typedef enum logic [0:0] {
    UMF_RTS_LOW  = 1'b0,   // receiver may accept more data
    UMF_RTS_HIGH = 1'b1    // receiver asks the far end to pause
  } umf_rts_state_t;

  // modem inputs, order matches change flag bits 3..0
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } umf_modem_t;

  // receive fifo fill and trigger thresholds from the channel
  typedef struct packed {
    logic [LVL_W-1:0] level;   // current fill
    logic [LVL_W-1:0] prog;    // programmed trigger level
    logic [LVL_W-1:0] upper;   // next trigger level above
    logic [LVL_W-1:0] lower;   // next trigger level below
  } umf_rxlvl_t;

  // software flow control selection handed to the data paths
  typedef struct packed {
    logic       enh_en;    // enhanced functions enabled
    logic [1:0] tx_sel;    // transmit character selection
    logic [1:0] rx_sel;    // receive compare selection
    logic       tx_pair;   // both transmit characters form one pair
    logic       rx_pair;   // both receive characters form one pair
  } umf_swflow_t;

endpackage : umf_pkg

/* File: logic/umf_sync_edge.sv */
module umf_sync_edge #(
  parameter int               W       = 4,
  parameter logic [W-1:0]     RST_VAL = '1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // raw pins
  input  wire logic [W-1:0] pin_raw,
  // filtered results
  output logic      [W-1:0] level,
  output logic      [W-1:0] changed,
  output logic      [W-1:0] rose
);

  // ==========================================================================
  // three stage synchroniser
  logic [W-1:0] s1_reg;       // metastable stage, read only by s2
  logic [W-1:0] s2_reg;       // second stage
  logic [W-1:0] s3_reg;       // third stage
  logic [W-1:0] level_next;   // accepted level

  // the level takes the second stage value when the second and third stages agree, and goes low otherwise
  assign level_next = (level & ~(s2_reg ^ s3_reg)) ^ ((s2_reg ^ level) & ~(s2_reg ^ s3_reg));

  // shift the pins in and accept agreed levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_reg  <= RST_VAL;
      s2_reg  <= RST_VAL;
      s3_reg  <= RST_VAL;
      level   <= RST_VAL;
      changed <= '0;
      rose    <= '0;
    end else begin
      s1_reg  <= pin_raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      level   <= level_next;
      changed <= level_next ^ level;
      rose    <= level_next & ~level;
    end
  end

endmodule : umf_sync_edge

/* File: logic/umf_modem_flow.sv */
// How it works
// - dsr and cts change flags set on toggle
// - any change flag raises modem interrupt
// - reading modem status clears all flags
// - status bits read inverse of pins
// - eight bit scratch register, no side effects
// - low four bits select software flow characters
// - auto cts stops transmitter while pin high
// - auto cts off after reset
// - auto rts interrupts at programmed trigger level
// - auto rts drives pin high at upper level
// - auto rts drops pin below lower level
// - auto rts bit reads live flow state
// - manual rts when hardware flow disabled
// - auto rts off after reset
module umf_modem_flow
  import umf_pkg::*;
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // ahb-lite slave
  input  wire logic                     hsel,
  input  wire logic [umf_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic                     hready,
  input  wire logic [umf_pkg::DATA_W-1:0] hwdata,
  output logic      [umf_pkg::DATA_W-1:0] hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // modem pins
  input  wire umf_pkg::umf_modem_t      modem_pins,
  output logic                          rts_pin,
  // channel side
  input  wire umf_pkg::umf_rxlvl_t      rx_lvl,
  output logic                          tx_stop,
  output umf_pkg::umf_swflow_t          swflow,
  // interrupts
  output logic                          modem_irq,
  output logic                          irq
);

  import umf_pkg::*;

  // ==========================================================================
  // bus address and data phase
  logic                   ahb_take;      // address phase accepted
  logic                   rd_take;       // read accepted this cycle
  logic                   wr_pend_reg;   // write data phase pending
  logic [ADDR_W-1:0]      wr_addr_reg;   // address of pending write
  logic                   wr_scr;        // scratch write strobe
  logic                   wr_efc;        // feature control write strobe
  logic                   wr_mctl;       // manual control write strobe
  logic                   wr_imsk;       // mask write strobe
  logic                   rd_mls;        // modem status read strobe
  logic                   rd_ist;        // interrupt status read strobe
  logic [DATA_W-1:0]      rd_word;       // read data selected by address

  // transfers with hsize below a word are accepted as whole words
  assign ahb_take = hsel & hready & (htrans != HTRANS_IDLE);
  assign rd_take  = ahb_take & ~hwrite;
  assign wr_scr   = wr_pend_reg & (wr_addr_reg == ADDR_SCR);
  assign wr_efc   = wr_pend_reg & (wr_addr_reg == ADDR_EFC);
  assign wr_mctl  = wr_pend_reg & (wr_addr_reg == ADDR_MCTL);
  assign wr_imsk  = wr_pend_reg & (wr_addr_reg == ADDR_IMSK);
  assign rd_mls   = rd_take & (haddr == ADDR_MLS);
  assign rd_ist   = rd_take & (haddr == ADDR_IST);

  // remember a write for its data phase, always zero wait, always okay
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hreadyout   <= 1'b1;
      hresp       <= HRESP_OKAY;
    end else begin
      wr_pend_reg <= ahb_take & hwrite;
      wr_addr_reg <= haddr;
      hreadyout   <= 1'b1;
      hresp       <= HRESP_OKAY;
    end
  end

  // ==========================================================================
  // modem inputs
  logic [3:0]             pin_lvl;      // accepted pin levels, cd ri dsr cts
  logic [3:0]             pin_chg;      // one cycle toggle pulses
  logic [3:0]             pin_rose;     // one cycle low to high pulses
  logic [CHG_W-1:0]       chg_set;      // change flags to set
  logic [CHG_W-1:0]       chg_reg;      // sticky change flags
  logic [CHG_W-1:0]       chg_next;     // next change flags
  logic [7:0]             mls_word;     // modem_line_status read value

  // pins come from the far end, so they pass the synchroniser first
  umf_sync_edge #(
    .W       (4),
    .RST_VAL (PIN_IDLE)
  ) u_pins (
    .mclk    (mclk),
    .rst     (rst),
    .pin_raw (modem_pins),
    .level   (pin_lvl),
    .changed (pin_chg),
    .rose    (pin_rose)
  );

  // ri flags only its rising edge, the others any toggle
  assign chg_set  = {pin_chg[3], pin_rose[2], pin_chg[1:0]};
  // a fresh change survives a clearing read in the same cycle
  assign chg_next = (chg_reg & ~{CHG_W{rd_mls}}) | chg_set;
  // upper nibble shows the complement of the accepted pins
  assign mls_word = {~pin_lvl, chg_reg};

  // change flags and modem interrupt line
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chg_reg   <= '0;
      modem_irq <= 1'b0;
    end else begin
      chg_reg   <= chg_next;
      modem_irq <= |chg_next;
    end
  end

  // ==========================================================================
  // software registers
  logic [7:0]             scr_reg;      // scratch_store
  logic [7:0]             efc_reg;      // extended_feature_ctrl
  logic [7:0]             mctl_reg;     // manual modem control
  logic [IST_W-1:0]       imsk_reg;     // interrupt mask
  logic                   auto_cts;     // automatic cts enabled
  logic                   auto_rts;     // automatic rts enabled
  logic [7:0]             efc_word;     // feature control read value

  assign auto_cts = efc_reg[EFC_AUTO_CTS];
  assign auto_rts = efc_reg[EFC_AUTO_RTS];

  // plain storage written in the data phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scr_reg  <= SCR_RST;
      efc_reg  <= EFC_RST;
      mctl_reg <= MCTL_RST;
      imsk_reg <= IMSK_RST;
    end else begin
      if (wr_scr) begin
        scr_reg <= hwdata[7:0];
      end
      if (wr_efc) begin
        efc_reg <= hwdata[7:0];
      end
      if (wr_mctl) begin
        mctl_reg <= hwdata[7:0];
      end
      if (wr_imsk) begin
        imsk_reg <= hwdata[IST_W-1:0];
      end
    end
  end

  // ==========================================================================
  // automatic rts and cts
  umf_rts_state_t         rts_state_reg;   // hardware flow state
  umf_rts_state_t         rts_state_next;  // next hardware flow state
  logic                   trig_hit;        // fill at or above programmed level
  logic                   trig_hit_d_reg;  // trig_hit one cycle ago
  logic                   ev_rxtrig;       // programmed level just reached

  assign trig_hit  = rx_lvl.level >= rx_lvl.prog;
  assign ev_rxtrig = auto_rts & trig_hit & ~trig_hit_d_reg;

  // pause at the upper level, release below the lower level
  always_comb begin
    rts_state_next = rts_state_reg;
    case (rts_state_reg)
      UMF_RTS_LOW: begin
        if (auto_rts && rx_lvl.level >= rx_lvl.upper) begin
          rts_state_next = UMF_RTS_HIGH;
        end
      end
      UMF_RTS_HIGH: begin
        if (!auto_rts || rx_lvl.level < rx_lvl.lower) begin
          rts_state_next = UMF_RTS_LOW;
        end
      end
      default: begin
        rts_state_next = UMF_RTS_LOW;
      end
    endcase
  end

  // pin drivers and the transmitter gate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rts_state_reg  <= UMF_RTS_LOW;
      trig_hit_d_reg <= 1'b0;
      rts_pin        <= RTS_PIN_RST;
      tx_stop        <= 1'b0;
      swflow         <= '0;
    end else begin
      rts_state_reg  <= rts_state_next;
      trig_hit_d_reg <= trig_hit;
      // manual level is the complement of the software request
      rts_pin        <= auto_rts ? (rts_state_next == UMF_RTS_HIGH)
                                 : ~mctl_reg[MCTL_SW_RTS];
      // far end holds cts high to pause us
      tx_stop        <= auto_cts & pin_lvl[0];
      swflow         <= '{enh_en:  efc_reg[EFC_ENH],
                          tx_sel:  efc_reg[3:2],
                          rx_sel:  efc_reg[1:0],
                          tx_pair: &efc_reg[3:2],
                          rx_pair: &efc_reg[1:0]};
    end
  end

  // auto rts bit reads set only while enabled and not pausing the far end
  assign efc_word = {efc_reg[7], auto_rts & (rts_state_reg == UMF_RTS_LOW),
                     efc_reg[5:0]};

  // ==========================================================================
  // interrupt status
  logic [IST_W-1:0]       ist_reg;    // sticky events
  logic [IST_W-1:0]       ist_set;    // events this cycle
  logic [IST_W-1:0]       ist_next;   // next sticky events

  assign ist_set  = {ev_rxtrig, |chg_set};
  assign ist_next = (ist_reg & ~{IST_W{rd_ist}}) | ist_set;

  // sticky bits, read clear, set wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ist_reg <= '0;
      irq     <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      irq     <= |(ist_next & imsk_reg);
    end
  end

  // ==========================================================================
  // read data, captured in the address phase
  assign rd_word = (haddr == ADDR_MLS)  ? {24'h000000, mls_word} :
                   (haddr == ADDR_SCR)  ? {24'h000000, scr_reg} :
                   (haddr == ADDR_EFC)  ? {24'h000000, efc_word} :
                   (haddr == ADDR_MCTL) ? {24'h000000, mctl_reg} :
                   (haddr == ADDR_IST)  ? {30'h0, ist_reg} :
                   (haddr == ADDR_IMSK) ? {30'h0, imsk_reg} :
                   (haddr == ADDR_FLOW) ? {24'h000000, tx_stop, rts_pin,
                                           rx_lvl.level} :
                   32'h00000000;

  // unmapped addresses read zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (rd_take) begin
      hrdata <= rd_word;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // change flags and modem interrupt
  a_chg_set_flag: assert property (chg_set[1:0] != 2'h0 |=>
    (chg_reg[1:0] & $past(chg_set[1:0])) == $past(chg_set[1:0]))
    else $error("change flag not set");
  a_modem_irq_level: assert property (modem_irq == (chg_reg != '0))
    else $error("modem interrupt wrong");
  a_modem_event: assert property (chg_set != '0 |=> ist_reg[IST_MODEM])
    else $error("modem event lost");
  a_read_clears: assert property (rd_mls && chg_set == '0 |=> chg_reg == '0)
    else $error("flags not cleared");
  a_set_beats_read: assert property (rd_mls && chg_set != '0 |=>
    chg_reg == $past(chg_set)) else $error("fresh change lost");
  a_status_inverse: assert property (rd_mls |=> hrdata[7:4] == ~$past(pin_lvl))
    else $error("status not inverse");
  // software registers
  a_scratch_hold: assert property (wr_scr |=> scr_reg == $past(hwdata[7:0]) ##1
    (scr_reg == $past(scr_reg) || $past(wr_scr))) else $error("scratch lost");
  a_swflow_pair: assert property (wr_efc |=> ##1
    swflow.tx_pair == (efc_reg[3:2] == 2'h3)) else $error("pair select wrong");
  // automatic cts
  a_cts_gate: assert property (auto_cts && pin_lvl[0] |=> tx_stop)
    else $error("tx not stopped");
  a_cts_free: assert property (!auto_cts |=> !tx_stop)
    else $error("tx stopped");
  a_flow_default: assert property ($past(rst) |-> efc_reg[7:6] == 2'h0)
    else $error("auto flow on at reset");
  // automatic rts
  a_trig_event: assert property (ev_rxtrig |=> ist_reg[IST_RXTRIG])
    else $error("trigger event lost");
  a_rts_raise: assert property (auto_rts && rx_lvl.level >= rx_lvl.upper |=> rts_pin)
    else $error("rts not raised");
  a_rts_drop: assert property (auto_rts && rts_state_reg == UMF_RTS_HIGH &&
    rx_lvl.level < rx_lvl.lower |=> !rts_pin) else $error("rts not dropped");
  a_rts_readback: assert property (rts_state_reg == UMF_RTS_HIGH |->
    !efc_word[EFC_AUTO_RTS]) else $error("auto rts readback wrong");
  a_rts_manual: assert property (!auto_rts |=>
    rts_pin == !$past(mctl_reg[MCTL_SW_RTS])) else $error("manual rts wrong");

  // main scenarios reached
  c_flag_read: cover property (rd_mls && chg_reg != '0);
  c_tx_pause: cover property ($rose(tx_stop));
  c_rts_cycle: cover property ($rose(rts_pin) && auto_rts);
  c_irq_out: cover property ($rose(irq));

endmodule : umf_modem_flow

/* File: verification/umf_modem_model.sv */
module umf_modem_model
  import umf_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rst,
  // requests from the bench
  input  wire logic           pause_req,   // far end wants the transmitter held
  input  wire logic [2:0]     line_on,     // {cd, ri, dsr} asserted, pin low
  // device side
  output umf_pkg::umf_modem_t modem_pins
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // pin drivers, idle high so no change shows after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modem_pins <= PIN_IDLE;
    end else begin
      modem_pins.cts_n <= pause_req;
      modem_pins.dsr_n <= ~line_on[0];     // active low line
      modem_pins.ri_n  <= ~line_on[1];
      modem_pins.cd_n  <= ~line_on[2];
    end
  end

endmodule : umf_modem_model

/* File: verification/uart_modem_status_flow_control_tb.sv */
module uart_modem_status_flow_control_tb;
  import umf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // bench signals
  logic                mclk = 1'b0;     // 40 MHz clock
  logic                rst  = 1'b1;     // reset held at start
  logic                hsel = 1'b0;
  logic [ADDR_W-1:0]   haddr = 8'h00;
  logic [1:0]          htrans = HTRANS_IDLE;
  logic                hwrite = 1'b0;
  logic [2:0]          hsize = 3'h2;
  logic [DATA_W-1:0]   hwdata = 32'h0;
  logic [DATA_W-1:0]   hrdata;
  logic                hreadyout;
  logic                hresp;
  umf_modem_t          modem_pins;
  logic                rts_pin;
  umf_rxlvl_t          rx_lvl = '{level:6'h00, prog:6'h08, upper:6'h10, lower:6'h04};
  logic                tx_stop;
  umf_swflow_t         swflow;
  logic                modem_irq;
  logic                irq;
  logic                pause_req = 1'b1;   // cts pin high
  logic [2:0]          line_on = 3'h0;     // other lines idle
  int                  error_cnt = 0;
  int                  tests_run = 0;
  logic [3:0]          s;                  // flow selection under test

  // ==========================================================================
  // clock
  always #12.5 mclk = ~mclk;

  // ==========================================================================
  // design and far side
  umf_modem_flow i_umf_modem_flow (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .modem_pins(modem_pins), .rts_pin(rts_pin), .rx_lvl(rx_lvl),
    .tx_stop(tx_stop), .swflow(swflow), .modem_irq(modem_irq), .irq(irq)
  );
  umf_modem_model i_umf_modem_model (
    .mclk(mclk), .rst(rst), .pause_req(pause_req), .line_on(line_on),
    .modem_pins(modem_pins)
  );

  // ==========================================================================
  // verdict, the one exit of the run
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // compare one value
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask : wait_rdy

  // one single ahb-lite word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, q, exp);
  endtask : rd

  // let n edges pass, then look between edges
  task automatic after(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : after

  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    after(1);
    chk("rts_pin", {31'h0, rts_pin}, 32'h1);
    chk("tx_stop", {31'h0, tx_stop}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    rd("efc", ADDR_EFC, 32'h00);
    rd("scratch", ADDR_SCR, {24'h0, SCR_RST});
    rd("mctl", ADDR_MCTL, 32'h00);
    rd("unmapped", 8'h1c, 32'h00);
    // scratch holds any byte, nothing else moves
    wr(ADDR_SCR, 32'h000000a5);
    rd("scratch", ADDR_SCR, 32'h000000a5);
    wr(ADDR_SCR, 32'h0000005a);
    rd("scratch", ADDR_SCR, 32'h0000005a);
    rd("efc", ADDR_EFC, 32'h00);
    rd("mls", ADDR_MLS, 32'h00);
    // each line change sets its flag, ri only on its rise, read clears
    @(posedge mclk) pause_req <= 1'b0;
    after(9);
    chk("modem_irq", {31'h0, modem_irq}, 32'h1);
    rd("mls", ADDR_MLS, 32'h11);
    after(1);
    chk("modem_irq", {31'h0, modem_irq}, 32'h0);
    rd("mls", ADDR_MLS, 32'h10);
    @(posedge mclk) line_on <= 3'h1;
    after(9);
    rd("mls", ADDR_MLS, 32'h32);
    @(posedge mclk) line_on <= 3'h5;
    after(9);
    rd("mls", ADDR_MLS, 32'hb8);
    @(posedge mclk) line_on <= 3'h7;
    after(9);
    rd("mls", ADDR_MLS, 32'hf0);
    @(posedge mclk) line_on <= 3'h5;
    after(9);
    rd("mls", ADDR_MLS, 32'hb4);
    @(posedge mclk) line_on <= 3'h0;
    pause_req <= 1'b1;
    after(9);
    rd("mls", ADDR_MLS, 32'h0b);
    // interrupt: sticky, masked, cleared by read
    chk("irq", {31'h0, irq}, 32'h0);
    rd("ist", ADDR_IST, 32'h01);
    wr(ADDR_IMSK, 32'h01);
    @(posedge mclk) pause_req <= 1'b0;
    after(9);
    chk("irq", {31'h0, irq}, 32'h1);
    rd("ist", ADDR_IST, 32'h01);
    after(1);
    chk("irq", {31'h0, irq}, 32'h0);
    rd("mls", ADDR_MLS, 32'h11);
    // software flow selection, every code
    for (int v = 0; v < 16; v++) begin
      s = v[3:0];
      wr(ADDR_EFC, {28'h1, s});
      rd("efc", ADDR_EFC, {28'h1, s});
      chk("swflow", {25'h0, swflow}, {25'h0, 1'b1, s, &s[3:2], &s[1:0]});
    end
    // automatic cts pause and resume
    wr(ADDR_EFC, 32'h80);
    @(posedge mclk) pause_req <= 1'b1;
    after(9);
    chk("tx_stop", {31'h0, tx_stop}, 32'h1);
    rd("flow", ADDR_FLOW, 32'hc0);
    @(posedge mclk) pause_req <= 1'b0;
    after(9);
    chk("tx_stop", {31'h0, tx_stop}, 32'h0);
    wr(ADDR_EFC, 32'h00);
    @(posedge mclk) pause_req <= 1'b1;
    after(9);
    chk("tx_stop", {31'h0, tx_stop}, 32'h0);
    rd("ist", ADDR_IST, 32'h01);
    // automatic rts with hysteresis
    wr(ADDR_IMSK, 32'h02);
    wr(ADDR_EFC, 32'h40);
    after(2);
    chk("rts_pin", {31'h0, rts_pin}, 32'h0);
    rd("efc", ADDR_EFC, 32'h40);
    @(posedge mclk) rx_lvl.level <= 6'h08;
    after(3);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("rts_pin", {31'h0, rts_pin}, 32'h0);
    rd("ist", ADDR_IST, 32'h02);
    @(posedge mclk) rx_lvl.level <= 6'h10;
    after(2);
    chk("rts_pin", {31'h0, rts_pin}, 32'h1);
    rd("efc", ADDR_EFC, 32'h00);
    @(posedge mclk) rx_lvl.level <= 6'h04;
    after(2);
    chk("rts_pin", {31'h0, rts_pin}, 32'h1);
    @(posedge mclk) rx_lvl.level <= 6'h03;
    after(2);
    chk("rts_pin", {31'h0, rts_pin}, 32'h0);
    // manual rts once hardware flow is off
    wr(ADDR_EFC, 32'h00);
    @(posedge mclk) rx_lvl.level <= 6'h14;
    after(2);
    chk("rts_pin", {31'h0, rts_pin}, 32'h1);
    wr(ADDR_MCTL, 32'h01);
    after(2);
    chk("rts_pin", {31'h0, rts_pin}, 32'h0);
    rd("efc", ADDR_EFC, 32'h00);
    conclude();
  end

endmodule : uart_modem_status_flow_control_tb
